// File: verilog/dcgl_defines.svh
// constants of the dual channel lane configuration register bank
`ifndef DCGL_DEFINES_SVH
`define DCGL_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define DCGL_REG_GLB   5'h00
`define DCGL_REG_CHC   5'h01
`define DCGL_GLB_RST   16'h0600
`define DCGL_CHC_RST   16'h0300
`define DCGL_B_SRST    15
`define DCGL_B_BCAST   11
`define DCGL_F_SEL     3:0
`define DCGL_B_SLEEP   15
`define DCGL_B_RX11    13
`define DCGL_B_TX11    12
`define DCGL_F_POL     11:10
`define DCGL_B_RXSPL   9
`define DCGL_B_TXMRG   8

// ----------------------------------------
// pass pin select codes
// ----------------------------------------
`define DCGL_SEL_HSA   4'h0
`define DCGL_SEL_HSB   4'h8
`define DCGL_SEL_LSA   2'h1
`define DCGL_SEL_LSB   2'h3

// ----------------------------------------
// management frame
// ----------------------------------------
`define DCGL_PHY_BASE  4'h0
`define DCGL_OP_WR     2'h1
`define DCGL_OP_RD     2'h2
`define DCGL_PRE_LEN   6'h20
`define DCGL_HDR_LAST  5'h0B
`define DCGL_TA_LAST   5'h01
`define DCGL_DAT_LAST  5'h0F

// ----------------------------------------
// ratios and sync policy
// ----------------------------------------
`define DCGL_RAT_1     2'h0
`define DCGL_RAT_2     2'h1
`define DCGL_RAT_4     2'h2
`define DCGL_POL_ETH   2'h0
`define DCGL_ACQ_LEN   2'h3
`define DCGL_GOOD_LAST 2'h3
`define DCGL_BAD_ETH   3'h4

`endif

// File: verilog/dcgl_pkg.sv
// types of the dual channel lane configuration register bank
package dcgl_pkg;

	typedef enum logic [5:0] {
		M_PRE = 6'h01,
		M_STB = 6'h02,
		M_HDR = 6'h04,
		M_TA  = 6'h08,
		M_DAT = 6'h10,
		M_IDL = 6'h20
	} dcgl_mfsm_t;

	typedef enum logic [1:0] {
		S_LOST = 2'h1,
		S_OK   = 2'h2
	} dcgl_sync_t;

	// per channel inputs from the datapath, same clock
	typedef struct packed {
		logic       code_stb;
		logic       code_err;
		logic       comma;
		logic       hs_pass;
		logic       hs_chk_en;
		logic       ls_chk_en;
		logic [3:0] ls_pass;
	} dcgl_chan_in_t;

	// per channel controls towards the datapath
	typedef struct packed {
		logic       sleep;
		logic [1:0] rx_ratio;
		logic [1:0] tx_ratio;
		logic       sync_ok;
	} dcgl_chan_out_t;

	typedef struct packed {
		logic                mdc_s1;
		logic                mdc_s2;
		logic                mdc_d;
		logic                mdi_s1;
		logic                mdi_s2;
		dcgl_mfsm_t          fsm;
		logic [5:0]          pre;
		logic [4:0]          cnt;
		logic [11:0]         hdr;
		logic [15:0]         sh;
		logic                hit;
		logic                rd;
		logic                mdo;
		logic                oe;
		logic [15:0]         glb;
		logic [1:0][15:0]    chc;
		dcgl_sync_t [1:0]    sst;
		logic [1:0][2:0]     bad;
		logic [1:0][1:0]     good;
		logic [1:0][1:0]     acq;
		logic                pass;
		logic                srst;
	} dcgl_state_t;

endpackage : dcgl_pkg

// File: verilog/dcgl_regs.sv
// management register bank with line synchronizers for both channels
`timescale 1ns/100ps
`include "dcgl_defines.svh"

module dcgl_regs (
	input  wire logic                   mclk,
	input  wire logic                   rst_b,
	input  wire logic                   mdc,
	input  wire logic                   mdio_i,
	output logic                        mdio_o,
	output logic                        mdio_oe,
	input  dcgl_pkg::dcgl_chan_in_t [1:0]  chan_in,
	output dcgl_pkg::dcgl_chan_out_t [1:0] chan_out,
	output logic                        pattern_check_pass_pin,
	output logic                        soft_reset_pulse
);
	import dcgl_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	// all state of the bank sits in one packed struct: frame engine, global and both
	// channel registers, both synchronizers and the pass pin flop
	// one copy is filled by the next-state process and registered in one place, so a
	// field that no branch touches simply keeps its value
	// the frame engine only moves on a synced mdc rising edge; the rest runs every mclk
	dcgl_state_t q_r;
	dcgl_state_t q_nxt;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic        rise;
		logic        mdi;
		logic [11:0] hw;
		logic [15:0] wd;
		logic [3:0]  sel;
		logic [1:0]  pol;
		logic [2:0]  nb;
		// hold by default; every local gets its value before any branch reads it
		// rise and mdi are the synced pin view, hw and wd the shifts with the new bit in
		q_nxt = q_r;
		rise  = q_r.mdc_s2 & ~q_r.mdc_d;
		mdi   = q_r.mdi_s2;
		hw    = {q_r.hdr[10:0], q_r.mdi_s2};
		wd    = {q_r.sh[14:0], q_r.mdi_s2};
		sel   = q_r.glb[`DCGL_F_SEL];
		pol   = 2'h0;
		nb    = 3'h0;
		// two flops on every pin before use
		// mdc_d is the edge detector's memory; it resets low like the idle pin,
		// so leaving reset never shows a false edge
		q_nxt.mdc_s1 = mdc;
		q_nxt.mdc_s2 = q_r.mdc_s1;
		q_nxt.mdc_d  = q_r.mdc_s2;
		q_nxt.mdi_s1 = mdio_i;
		q_nxt.mdi_s2 = q_r.mdi_s1;
		// the pulse lasts exactly one mclk whatever else happens
		q_nxt.srst   = 1'b0;

		// ----------------------------------------
		// frame engine
		// ----------------------------------------
		// an edge is seen three mclk after it happened at the pin; the station moved mdio half
		// an mdc period before that edge, so the sampled bit has long settled by then
		// hence roughly two mclk per mdc half period at least: closer edges would be lost
		if (rise) begin
			// self clearing soft reset, one management clock later
			// acts like the reset pin on registers and synchronizers, but the frame engine
			// runs on so that the frame carrying this edge is still decoded
			if (q_r.glb[`DCGL_B_SRST]) begin
				q_nxt.glb  = `DCGL_GLB_RST;
				q_nxt.chc  = {2{`DCGL_CHC_RST}};
				q_nxt.sst[0] = S_LOST;
				q_nxt.sst[1] = S_LOST;
				q_nxt.bad  = '0;
				q_nxt.good = '0;
				q_nxt.acq  = '0;
				q_nxt.srst = 1'b1;
			end
			unique case (q_r.fsm)
				M_PRE: begin
					// count ones up to 32 and saturate; a zero after a full preamble is the
					// first start bit, a zero after a short one only starts the count again
					q_nxt.oe = 1'b0;
					if (mdi) begin
						if (q_r.pre != `DCGL_PRE_LEN)
							q_nxt.pre = q_r.pre + 6'h01;
					end else begin
						if (q_r.pre == `DCGL_PRE_LEN)
							q_nxt.fsm = M_STB;
						q_nxt.pre = 6'h00;
					end
				end
				M_STB: begin
					// second start bit must be one
					// a zero here means noise or a short preamble, so hunt again
					q_nxt.fsm = mdi ? M_HDR : M_PRE;
					q_nxt.cnt = `DCGL_HDR_LAST;
				end
				M_HDR: begin
					// twelve bits: op code, phy address and register, decoded once the last is in
					q_nxt.hdr = hw;
					if (q_r.cnt == 5'h00) begin
						// only this phy pair answers, and only to the two legal op codes;
						// address bit 0 picks the channel
						q_nxt.rd  = (hw[11:10] == `DCGL_OP_RD);
						q_nxt.hit = (hw[9:6] == `DCGL_PHY_BASE) &&
							((hw[11:10] == `DCGL_OP_RD) || (hw[11:10] == `DCGL_OP_WR));
						// capture read data at the end of the header
						// a snapshot, so the word on the line cannot change half way through
						if (hw[4:0] == `DCGL_REG_GLB)
							q_nxt.sh = q_r.glb;
						else if (hw[4:0] == `DCGL_REG_CHC)
							q_nxt.sh = q_r.chc[hw[5]];
						// unmapped registers on this phy read back as zero
						else
							q_nxt.sh = 16'h0000;
						q_nxt.fsm = M_TA;
						q_nxt.cnt = `DCGL_TA_LAST;
					end else begin
						q_nxt.cnt = q_r.cnt - 5'h01;
					end
				end
				M_TA: begin
					// reads: zero in the second turnaround bit, the top data bit in the first data bit;
					// writes and foreign frames leave the line to the station
					if (q_r.cnt == 5'h00) begin
						q_nxt.fsm = M_DAT;
						q_nxt.cnt = `DCGL_DAT_LAST;
						if (q_r.rd && q_r.hit) begin
							q_nxt.mdo = q_r.sh[15];
							q_nxt.sh  = {q_r.sh[14:0], 1'b0};
						end
					end else begin
						q_nxt.cnt = q_r.cnt - 5'h01;
						// turnaround zero driven in the second bit
						if (q_r.rd && q_r.hit) begin
							q_nxt.oe  = 1'b1;
							q_nxt.mdo = 1'b0;
						end
					end
				end
				M_DAT: begin
					// reads shift the snapshot out, writes shift the line in
					if (q_r.rd) begin
						q_nxt.mdo = q_r.sh[15];
						q_nxt.sh  = {q_r.sh[14:0], 1'b0};
					end else begin
						q_nxt.sh = wd;
					end
					// commit only on the last bit, so a frame cut short never touches a register;
					// the line is let go at the same edge so the station can start the next preamble
					if (q_r.cnt == 5'h00) begin
						q_nxt.fsm = M_PRE;
						q_nxt.pre = 6'h00;
						q_nxt.oe  = 1'b0;
						if (!q_r.rd && q_r.hit) begin
							// reserved global bits are stored as written; keeping them is up to software
							if (q_r.hdr[4:0] == `DCGL_REG_GLB)
								q_nxt.glb = wd;
							else if (q_r.hdr[4:0] == `DCGL_REG_CHC) begin
								for (int c = 0; c < 2; c++) begin
									// broadcast copies the write to both channels
									// only the per-channel register has two copies to reach
									if ((c[0] == q_r.hdr[5]) || q_r.glb[`DCGL_B_BCAST])
										q_nxt.chc[c] = wd;
								end
							end
						end
					end else begin
						q_nxt.cnt = q_r.cnt - 5'h01;
					end
				end
				// not entered today; kept so an odd code falls back to hunting a preamble
				M_IDL: q_nxt.fsm = M_PRE;
				default: q_nxt.fsm = M_PRE;
			endcase
		end

		// ----------------------------------------
		// pass pin
		// ----------------------------------------
		// pass pin routing, low when checking is off or code reserved
		// one flop after the select, so the pin does not glitch while select or lanes change;
		// a reserved code holds the pin low rather than showing a stale lane
		if (sel == `DCGL_SEL_HSA)
			q_nxt.pass = chan_in[0].hs_pass & chan_in[0].hs_chk_en;
		else if (sel == `DCGL_SEL_HSB)
			q_nxt.pass = chan_in[1].hs_pass & chan_in[1].hs_chk_en;
		else if (sel[3:2] == `DCGL_SEL_LSA)
			q_nxt.pass = chan_in[0].ls_pass[sel[1:0]] & chan_in[0].ls_chk_en;
		else if (sel[3:2] == `DCGL_SEL_LSB)
			q_nxt.pass = chan_in[1].ls_pass[sel[1:0]] & chan_in[1].ls_chk_en;
		else
			q_nxt.pass = 1'b0;

		// ----------------------------------------
		// line synchronizers
		// ----------------------------------------
		// line synchronizers, held lost while the channel sleeps
		// a plain loop over both channels keeps the single next-state process;
		// the two copies share nothing but the loop variable and the pol and nb temporaries
		for (int c = 0; c < 2; c++) begin
			// policy field and error count plus one, used by both policy kinds
			pol = q_r.chc[c][`DCGL_F_POL];
			nb  = q_r.bad[c] + 3'h1;
			if (q_r.chc[c][`DCGL_B_SLEEP]) begin
				q_nxt.sst[c]  = S_LOST;
				q_nxt.acq[c]  = 2'h0;
			end else if (chan_in[c].code_stb && !q_r.glb[`DCGL_B_SRST]) begin
				// codes are ignored while a soft reset is pending, it clears the channel anyway
				unique case (q_r.sst[c])
					S_LOST: begin
						// three clean commas acquire, clean non-commas leave the count; an error starts the count again
						if (chan_in[c].code_err)
							q_nxt.acq[c] = 2'h0;
						else if (chan_in[c].comma)
							q_nxt.acq[c] = q_r.acq[c] + 2'h1;
						if (!chan_in[c].code_err && chan_in[c].comma &&
							(q_r.acq[c] + 2'h1 == `DCGL_ACQ_LEN)) begin
							q_nxt.sst[c]  = S_OK;
							q_nxt.bad[c]  = 3'h0;
							q_nxt.good[c] = 2'h0;
							q_nxt.acq[c]  = 2'h0;
						end
					end
					S_OK: begin
						// policy 00 keeps a leaky error count, the others count a run of errors
						if (pol == `DCGL_POL_ETH) begin
							// errors pile up, runs of four good codes pay one back
							if (chan_in[c].code_err) begin
								q_nxt.bad[c]  = nb;
								q_nxt.good[c] = 2'h0;
								// four errors in the count drop sync
								if (nb == `DCGL_BAD_ETH)
									q_nxt.sst[c] = S_LOST;
							end else if (q_r.bad[c] != 3'h0) begin
								q_nxt.good[c] = q_r.good[c] + 2'h1;
								if (q_r.good[c] == `DCGL_GOOD_LAST) begin
									q_nxt.bad[c]  = q_r.bad[c] - 3'h1;
									q_nxt.good[c] = 2'h0;
								end
							end
						end else begin
							// policy code equals the run of errors that drops sync
							if (chan_in[c].code_err) begin
								q_nxt.bad[c] = nb;
								if (nb == {1'b0, pol})
									q_nxt.sst[c] = S_LOST;
							end else begin
								q_nxt.bad[c] = 3'h0;
							end
						end
					end
					default: q_nxt.sst[c] = S_LOST;
				endcase
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// asynchronous reset loads constants only; the soft reset goes through the
	// next-state logic, so it stays a clean synchronous path
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q_r     <= '0;
			q_r.fsm <= M_PRE;
			q_r.glb <= `DCGL_GLB_RST;
			q_r.chc <= {2{`DCGL_CHC_RST}};
			q_r.sst[0] <= S_LOST;
			q_r.sst[1] <= S_LOST;
		end else begin
			// the whole bank in one register, nothing else holds state
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// straight from flops, so no decode glitch ever reaches a pin
	assign mdio_o                 = q_r.mdo;
	assign mdio_oe                = q_r.oe;
	assign pattern_check_pass_pin = q_r.pass;
	assign soft_reset_pulse       = q_r.srst;

	// ratio decode per channel
	// stored bits decoded into levels that the datapath treats as static between writes;
	// the direct bit wins over the split and merge bits
	for (genvar g = 0; g < 2; g++) begin : g_chan
		assign chan_out[g].sleep    = q_r.chc[g][`DCGL_B_SLEEP];
		assign chan_out[g].rx_ratio = q_r.chc[g][`DCGL_B_RX11] ? `DCGL_RAT_1 :
			(q_r.chc[g][`DCGL_B_RXSPL] ? `DCGL_RAT_4 : `DCGL_RAT_2);
		assign chan_out[g].tx_ratio = q_r.chc[g][`DCGL_B_TX11] ? `DCGL_RAT_1 :
			(q_r.chc[g][`DCGL_B_TXMRG] ? `DCGL_RAT_4 : `DCGL_RAT_2);
		assign chan_out[g].sync_ok  = (q_r.sst[g] == S_OK);
	end

endmodule : dcgl_regs

// File: tb/dcgl_regs_sva.sv
// port assertions for the lane configuration register bank
`timescale 1ns/100ps

module dcgl_regs_sva (
	input wire logic                      mclk,
	input wire logic                      rst_b,
	input wire logic                      mdc,
	input wire logic                      mdio_i,
	input wire logic                      mdio_o,
	input wire logic                      mdio_oe,
	input dcgl_pkg::dcgl_chan_in_t [1:0]  chan_in,
	input dcgl_pkg::dcgl_chan_out_t [1:0] chan_out,
	input wire logic                      pattern_check_pass_pin,
	input wire logic                      soft_reset_pulse
);
	import dcgl_pkg::*;
	// one domain, so clock and reset are given once
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// ----
	// soft reset
	// ----
	a_srst_one_cycle: assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("soft reset pulse longer than one cycle");
	a_srst_reg_dflt: assert property (soft_reset_pulse |=> chan_out[0].rx_ratio == 2'h2 &&
		chan_out[1].tx_ratio == 2'h2 && !chan_out[0].sleep && !chan_out[1].sleep)
		else $error("channel registers not at defaults after soft reset");
	a_srst_unsync: assert property (soft_reset_pulse |=> !chan_out[0].sync_ok && !chan_out[1].sync_ok)
		else $error("synchronizer still in sync after soft reset");

	// ----
	// synchronizer
	// ----
	a_sleep_unsync: assert property (chan_out[1].sleep |=> !chan_out[1].sync_ok)
		else $error("sleeping channel still in sync");
	a_good_keeps: assert property (chan_out[0].sync_ok && chan_in[0].code_stb && !chan_in[0].code_err
		|=> chan_out[0].sync_ok || soft_reset_pulse || chan_out[0].sleep)
		else $error("sync lost on a good code");
	a_sync_cause: assert property ($rose(chan_out[0].sync_ok) |-> $past(chan_in[0].code_stb) &&
		$past(chan_in[0].comma) && !$past(chan_in[0].code_err))
		else $error("sync gained without a clean comma");
	a_drop_on_err: assert property ($fell(chan_out[0].sync_ok) |-> $past(chan_in[0].code_err) ||
		$past(chan_out[0].sleep) || soft_reset_pulse)
		else $error("sync lost without an error");

	// ----
	// pass pin
	// ----
	a_pass_disabled: assert property (!chan_in[0].hs_chk_en && !chan_in[0].ls_chk_en &&
		!chan_in[1].hs_chk_en && !chan_in[1].ls_chk_en |=> !pattern_check_pass_pin)
		else $error("pass pin high with all checks off");
endmodule : dcgl_regs_sva

bind dcgl_regs dcgl_regs_sva sva_i (.mclk(mclk), .rst_b(rst_b), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
	.mdio_oe(mdio_oe), .chan_in(chan_in), .chan_out(chan_out), .pattern_check_pass_pin(pattern_check_pass_pin),
	.soft_reset_pulse(soft_reset_pulse));

// File: tb/dcgl_station.sv
// management station model driving whole frames on the mdc and mdio pins
`timescale 1ns/100ps

module dcgl_station (
	output logic        mdc,
	output logic        sta_o,
	output logic        sta_oe,
	input  wire logic   mdio,
	output logic [15:0] rd_data,
	output logic        rd_vld
);
	// idle: clock stands still low, line released to its pull-up
	initial begin
		mdc     = 1'b0;
		sta_o   = 1'b1;
		sta_oe  = 1'b0;
		rd_data = 16'h0000;
		rd_vld  = 1'b0;
	end

	// drive on the low phase, sample as mdc rises; let go at turnaround on reads
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd);
		logic [63:0] f;
		f = {32'hFFFFFFFF, 2'b01, op, phy, rg, 2'b10, wd};
		for (int i = 0; i < 64; i++) begin
			sta_oe = !(op == 2'h2 && i >= 46);
			sta_o  = f[63 - i];
			#62.5;
			mdc = 1'b1;
			if (i >= 48)
				rd_data = {rd_data[14:0], mdio};
			#62.5;
			mdc = 1'b0;
		end
		sta_oe = 1'b0;
		rd_vld = op == 2'h2;
		#62.5;
		rd_vld = 1'b0;
	endtask : frame
endmodule : dcgl_station

// File: tb/dcgl_regs_test.sv
// self-checking bench for the lane configuration register bank
`timescale 1ns/100ps

module dcgl_regs_test;
	import dcgl_pkg::*;
	logic                 mclk, rst_b, mdio_o, mdio_oe, pin, srst, mdc, sta_o, sta_oe, rd_vld;
	wire logic            mdio;
	logic [15:0]          rd_data;
	dcgl_chan_in_t [1:0]  chan_in;
	dcgl_chan_out_t [1:0] chan_out;
	int                   failures, cmp_count, n;
	logic [15:0]          exp_q[$];

	// released line floats to its pull-up
	assign mdio = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);

	dcgl_regs dut (.mclk(mclk), .rst_b(rst_b), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
		.chan_in(chan_in), .chan_out(chan_out), .pattern_check_pass_pin(pin), .soft_reset_pulse(srst));
	dcgl_station sta (.mdc(mdc), .sta_o(sta_o), .sta_oe(sta_oe), .mdio(mdio), .rd_data(rd_data), .rd_vld(rd_vld));

	// ----
	// helpers
	// ----
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// frames start 1 ns after a falling edge so no mdc or mdio change meets an mclk edge
	task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
		@(negedge mclk);
		#1;
		sta.frame(2'h1, p, r, d);
	endtask : wr

	task automatic rd(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
		exp_q.push_back(e);
		@(negedge mclk);
		#1;
		sta.frame(2'h2, p, r, 16'hFFFF);
	endtask : rd

	// one code group on channel A, one-cycle strobe
	task automatic cg(input logic e, input logic cm);
		@(negedge mclk);
		chan_in[0].code_stb = 1'b1;
		chan_in[0].code_err = e;
		chan_in[0].comma    = cm;
		@(negedge mclk);
		chan_in[0].code_stb = 1'b0;
	endtask : cg

	task automatic sk(input logic v);
		repeat (2) @(negedge mclk);
		chk("sync", 16'(v), 16'(chan_out[0].sync_ok));
	endtask : sk

	// pin value worked out from select code and check inputs
	function automatic logic pexp(input logic [3:0] s);
		if (s[2])
			pexp = chan_in[s[3]].ls_chk_en && chan_in[s[3]].ls_pass[s[1:0]];
		else
			pexp = s[1:0] == 2'h0 && chan_in[s[3]].hs_chk_en && chan_in[s[3]].hs_pass;
	endfunction : pexp

	task automatic stop_test;
		if (exp_q.size() != 0)
			failures++;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// ----
	// clock, monitor, watchdog
	// ----
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// each finished read is matched against the oldest note
	always @(posedge rd_vld) begin
		chk("read", exp_q.pop_front(), rd_data);
	end

	// a hang counts as a mismatch
	initial begin
		#400000;
		failures++;
		stop_test();
	end

	// ----
	// scenarios
	// ----
	initial begin
		void'($urandom(86));
		rst_b   = 1'b0;
		chan_in = '0;
		repeat (5) @(negedge mclk);
		rst_b = 1'b1;
		rd(5'h00, 5'h00, 16'h0600);
		rd(5'h00, 5'h01, 16'h0300);
		rd(5'h00, 5'h02, 16'h0000);
		rd(5'h02, 5'h00, 16'hFFFF);
		chk("tx ratio", 16'h0002, 16'(chan_out[1].tx_ratio));
		wr(5'h00, 5'h01, 16'h3000);
		chk("rx ratio", 16'h0000, 16'(chan_out[0].rx_ratio));
		chk("tx ratio", 16'h0000, 16'(chan_out[0].tx_ratio));
		chk("rx ratio", 16'h0002, 16'(chan_out[1].rx_ratio));
		wr(5'h00, 5'h01, 16'h0000);
		chk("rx ratio", 16'h0001, 16'(chan_out[0].rx_ratio));
		chk("tx ratio", 16'h0001, 16'(chan_out[0].tx_ratio));
		wr(5'h00, 5'h00, 16'h0E00);
		wr(5'h01, 5'h01, 16'h8000);
		chk("sleep", 16'h0001, 16'(chan_out[0].sleep));
		rd(5'h00, 5'h01, 16'h8000);
		wr(5'h01, 5'h01, 16'h0300);
		wr(5'h00, 5'h00, 16'h0600);
		for (int s = 0; s < 16; s++) begin
			wr(5'h00, 5'h00, 16'h0600 | 16'(s));
			repeat (4) begin
				@(negedge mclk);
				chan_in = 20'($urandom) & 20'h1FC7F;
				repeat (2) @(negedge mclk);
				chk("pass pin", 16'(pexp(4'(s))), 16'(pin));
			end
		end
		chan_in = '0;
		for (int p = 0; p < 4; p++) begin
			wr(5'h00, 5'h01, 16'h0300 | 16'(p << 10));
			repeat (3) cg(1'b0, 1'b1);
			sk(1'b1);
			n = (p == 0) ? 4 : p;
			repeat (n - 1) cg(1'b1, 1'b0);
			// four good codes pay one error back under policy 00, one clears the run otherwise
			repeat ((p == 0) ? 4 : 1) cg(1'b0, 1'b0);
			repeat ((p == 0) ? 1 : n - 1) cg(1'b1, 1'b0);
			sk(1'b1);
			cg(1'b1, 1'b0);
			sk(1'b0);
		end
		wr(5'h00, 5'h01, 16'h3400);
		wr(5'h00, 5'h00, 16'h8600);
		rd(5'h00, 5'h00, 16'h0600);
		rd(5'h00, 5'h01, 16'h0300);
		stop_test();
	end
endmodule : dcgl_regs_test
